// [rtl/fpm_core.sv]
// Power state and interface mode command handling of a serial flash.
// Link logic runs on the host serial clock; state logic runs on clk.
// Chip select frames the link: link words are read by clk only after chip select settles high.
`timescale 1ns/1ps
`default_nettype none

module fpm_core #(
    parameter logic [7:0] DEVICE_ID = 8'h5C,  // Arbitrary identifier value
    parameter int unsigned POWERUP_CYC = fpm_pkg::POWERUP_CYC
) (
    // System clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // Core status inputs
    input wire logic write_in_progress_flag,
    input wire logic write_enable_latch,
    // State outputs
    output logic core_reset,
    output logic deep_sleep,
    output logic standby,
    output logic quad_mode,
    output logic ready,
    output logic [15:0] status_word
);

    localparam int unsigned PW = $clog2(POWERUP_CYC + 1);

    // Reset release
    logic rst_m;
    logic rst_n;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    fpm_pkg::fpm_state_e state;
    fpm_pkg::fpm_state_e next_state;
    fpm_pkg::fpm_link_cfg_s cfg;

    // Quad bit is held steady across each frame, since it only moves after chip select rises; asleep and busy can change mid-frame
    assign cfg = '{quad: quad_mode, asleep: deep_sleep, busy: write_in_progress_flag};

    // ---------------- Link domain ----------------
    wire link_idle = cs_n | ~arst_n;
    logic fresh;
    logic [5:0] cnt;
    logic [31:0] shreg;
    logic [7:0] op;
    logic [7:0] addr;
    logic [2:0] sub;
    logic [7:0] tx;

    always_ff @(posedge sclk or posedge link_idle) begin
        if (link_idle) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    wire [31:0] next_shreg = cfg.quad ? {shreg[27:0], io_in} : {shreg[30:0], io_in[0]};
    wire [5:0] next_cnt = fresh ? 6'h01 : ((cnt == 6'h3F) ? cnt : cnt + 6'h01);
    wire [5:0] op_end = fpm_pkg::op_beats(cfg.quad);
    wire [5:0] addr_end = fpm_pkg::addr_beats(cfg.quad);
    wire [5:0] hdr = fpm_pkg::hdr_beats(cfg.quad, op);
    wire in_data = !fresh && (cnt >= hdr);
    wire [2:0] last_sub = cfg.quad ? fpm_pkg::QUAD_LAST_SUB : fpm_pkg::SPI_LAST_SUB;
    wire byte_done = in_data && (sub == last_sub);

    // Identifier is refused while a cycle runs; table reads are refused asleep
    wire talk_id = (op == fpm_pkg::OP_WAKE_ID) && !cfg.busy;
    wire talk_tab = (op == fpm_pkg::OP_PARAM_READ) && !cfg.asleep;
    wire talk = in_data && (talk_id || talk_tab);
    wire [7:0] tab_byte = (addr < 8'(fpm_pkg::PARAM_TABLE_LEN))
        ? fpm_pkg::PARAM_TABLE[addr[2:0]] : fpm_pkg::ERASED_BYTE;
    wire [7:0] tx_byte = (op == fpm_pkg::OP_WAKE_ID) ? DEVICE_ID : tab_byte;

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 6'h00;
            shreg <= 32'h0000_0000;
            op <= 8'h00;
            addr <= 8'h00;
            sub <= 3'h0;
        end else if (!cs_n) begin
            shreg <= next_shreg;
            cnt <= next_cnt;
            sub <= byte_done || !in_data ? 3'h0 : sub + 3'h1;
            if (next_cnt == op_end) begin
                op <= next_shreg[7:0];
            end
            if (next_cnt == addr_end) begin
                addr <= next_shreg[7:0];
            end else if (byte_done) begin
                addr <= addr + 8'h01;
            end
        end
    end

    // New byte at each byte start; the identifier simply reloads and repeats
    wire [7:0] next_tx = (sub == 3'h0) ? tx_byte
        : (cfg.quad ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0});

    // Outputs change on the falling edge; chip select high ends the transfer
    always_ff @(negedge sclk or posedge link_idle) begin
        if (link_idle) begin
            tx <= 8'h00;
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end else begin
            tx <= next_tx;
            io_out <= cfg.quad ? next_tx[7:4] : {2'b00, next_tx[7], 1'b0};
            io_oe <= !talk ? 4'h0 : (cfg.quad ? 4'hF : 4'h2);
        end
    end

    // ---------------- System clock domain ----------------
    logic [2:0] cs_sync;
    logic cs_st;
    logic rst_arm;
    logic [11:0] timer;
    logic [PW-1:0] pwr_cnt;
    fpm_pkg::fpm_frame_s frm;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync <= 3'b111;
            cs_st <= 1'b1;
        end else begin
            cs_sync <= {cs_sync[1:0], cs_n};
            if (cs_sync[1] == cs_sync[2]) begin
                cs_st <= cs_sync[2];
            end
        end
    end

    // Link counters stand still once chip select is high, so they are read directly here
    assign frm = '{beats: cnt, op: op};
    wire frame_end = cs_sync[1] & cs_sync[2] & ~cs_st;
    wire pwr_ok = (pwr_cnt == PW'(POWERUP_CYC));
    wire exact = (frm.beats == op_end);
    wire id_frame = (frm.beats >= addr_end);
    wire awake = (state == fpm_pkg::ST_STANDBY);
    // Busy states accept no command at all
    wire cmd = frame_end && pwr_ok && (awake || state == fpm_pkg::ST_SLEEP);
    wire cmd_exact = cmd && exact;

    wire go_reset = cmd_exact && rst_arm && (frm.op == fpm_pkg::OP_RST);
    wire go_sleep = awake && cmd_exact && (frm.op == fpm_pkg::OP_SLEEP)
        && !write_in_progress_flag;
    wire go_wake = (state == fpm_pkg::ST_SLEEP) && cmd && (frm.op == fpm_pkg::OP_WAKE_ID)
        && !write_in_progress_flag && (exact || id_frame);
    wire go_quad_on = awake && cmd_exact && (frm.op == fpm_pkg::OP_QUAD_ON) && !quad_mode;
    wire go_quad_off = awake && cmd_exact && (frm.op == fpm_pkg::OP_QUAD_OFF) && quad_mode;
    wire [11:0] wake_len = exact ? fpm_pkg::WAKE_CYC : fpm_pkg::ID_WAKE_CYC;

    always_comb begin
        next_state = state;
        unique case (state)
            fpm_pkg::ST_STANDBY: begin
                if (go_reset) begin
                    next_state = fpm_pkg::ST_RESET;
                end else if (go_sleep) begin
                    next_state = fpm_pkg::ST_ENTER;
                end
            end
            fpm_pkg::ST_ENTER: begin
                if (timer == 12'h000) begin
                    next_state = fpm_pkg::ST_SLEEP;
                end
            end
            fpm_pkg::ST_SLEEP: begin
                if (go_reset) begin
                    next_state = fpm_pkg::ST_RESET;
                end else if (go_wake) begin
                    next_state = fpm_pkg::ST_WAKE;
                end
            end
            fpm_pkg::ST_WAKE, fpm_pkg::ST_RESET: begin
                if (timer == 12'h000) begin
                    next_state = fpm_pkg::ST_STANDBY;
                end
            end
            default: begin
                next_state = fpm_pkg::ST_STANDBY;
            end
        endcase
    end

    wire [11:0] next_timer = go_reset ? fpm_pkg::SW_RESET_CYC - 12'h001
        : go_sleep ? fpm_pkg::SLEEP_ENTRY_CYC - 12'h001
        : go_wake ? wake_len - 12'h001
        : (timer != 12'h000) ? timer - 12'h001 : 12'h000;
    // Only the mode bit moves; latch, suspend and wrap state live elsewhere untouched
    wire next_quad = go_reset ? 1'b0 : go_quad_on ? 1'b1 : go_quad_off ? 1'b0 : quad_mode;
    wire [15:0] next_status = fpm_pkg::STATUS_RESET
        | (16'(write_in_progress_flag) << fpm_pkg::STAT_BUSY_BIT)
        | (16'(write_enable_latch) << fpm_pkg::STAT_LATCH_BIT);

    // Power-on reset lands in standby, never asleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= fpm_pkg::ST_STANDBY;
            timer <= 12'h000;
            quad_mode <= 1'b0;
            deep_sleep <= 1'b0;
            rst_arm <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            quad_mode <= next_quad;
            deep_sleep <= (next_state == fpm_pkg::ST_SLEEP);
            if (frame_end) begin
                rst_arm <= cmd_exact && (frm.op == fpm_pkg::OP_RST_ENABLE);
            end
        end
    end

    // Power-up guard also covers hosts that skip the supply settling wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_cnt <= '0;
            ready <= 1'b0;
        end else begin
            pwr_cnt <= pwr_ok ? pwr_cnt : pwr_cnt + PW'(1);
            ready <= pwr_ok;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_reset <= 1'b0;
            standby <= 1'b0;
            status_word <= fpm_pkg::STATUS_RESET;
        end else begin
            core_reset <= go_reset;
            standby <= cs_st && !write_in_progress_flag && awake;
            status_word <= next_status;
        end
    end

    // ---------------- Checks ----------------
    chk_sleep_only_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (state == fpm_pkg::ST_SLEEP && $past(state) != fpm_pkg::ST_SLEEP)
        |-> $past(state) == fpm_pkg::ST_ENTER)
        else $error("sleep reached without entry delay");

    chk_sleep_exact_frame: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && frame_end && !exact) |=> state != fpm_pkg::ST_ENTER)
        else $error("sleep started on a frame of wrong length");

    chk_entry_delay_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state == fpm_pkg::ST_ENTER)
        |-> timer == fpm_pkg::SLEEP_ENTRY_CYC - 12'h001 ##1 state == fpm_pkg::ST_ENTER)
        else $error("sleep entry delay not loaded");

    chk_sleep_busy_reject: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && frame_end && write_in_progress_flag) |=> state != fpm_pkg::ST_ENTER)
        else $error("sleep taken during busy cycle");

    chk_sleep_ignores: assert property (@(posedge clk) disable iff (!rst_n)
        (state == fpm_pkg::ST_SLEEP && frame_end && frm.op != fpm_pkg::OP_WAKE_ID
            && frm.op != fpm_pkg::OP_RST) |=> state == fpm_pkg::ST_SLEEP && $stable(quad_mode))
        else $error("command acted on while asleep");

    chk_wake_holdoff: assert property (@(posedge clk) disable iff (!rst_n)
        (state == fpm_pkg::ST_WAKE && timer != 12'h000) |=> state == fpm_pkg::ST_WAKE
            && $stable(quad_mode))
        else $error("wake delay cut short");

    chk_wake_busy_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        (state == fpm_pkg::ST_SLEEP && frame_end && write_in_progress_flag)
        |=> state != fpm_pkg::ST_WAKE)
        else $error("wake accepted while busy");

    chk_quad_enter: assert property (@(posedge clk) disable iff (!rst_n)
        go_quad_on |=> quad_mode ##1 quad_mode)
        else $error("quad command mode not entered");

    chk_quad_exit: assert property (@(posedge clk) disable iff (!rst_n)
        (awake && cmd_exact && quad_mode && frm.op == fpm_pkg::OP_QUAD_OFF) |=> !quad_mode)
        else $error("quad command mode not left");

    chk_reset_seq: assert property (@(posedge clk) disable iff (!rst_n)
        go_reset |=> core_reset && state == fpm_pkg::ST_RESET && !quad_mode && !deep_sleep)
        else $error("software reset not carried out");

    chk_standby_not_sleep: assert property (@(posedge clk) disable iff (!rst_n)
        standby |-> !deep_sleep && $past(cs_st))
        else $error("standby shown while asleep or selected");

endmodule // fpm_core

`default_nettype wire

// [pkg/fpm_pkg.sv]
// Constants, types and helpers for the flash power and interface mode command block.
// Assumes a 50 MHz system clock and a host that owns chip select and the serial clock.
// Function
// - Only the sleep opcode B9H puts the device into the sleep state.
// - While asleep, ignore everything except wake/identify ABH and software reset.
// - Chip select high with no internal cycle means standby, not sleep.
// - Sleep runs only if chip select rises right after the eighth opcode bit.
// - After a valid sleep frame, wait the sleep entry delay before sleeping.
// - Sleep request during a program, erase or status write is rejected.
// - Power-up always starts in standby, never in sleep.
// - Wake is ABH alone, then no command accepted until the wake delay ends.
// - Identify is ABH plus three dummy bytes, identifier out MSB first on falling edges.
// - Identifier byte repeats while clocks continue; chip select high ends it.
// - Identify that also wakes needs the identify-wake delay before new commands.
// - Wake/identify is ignored while the write-in-progress flag is set.
// - Opcode 38H in SPI mode switches to quad command mode.
// - Opcode FFH in quad command mode returns to SPI mode.
// - Mode switches keep write enable latch, suspend status and wrap length.
// - Opcode 5AH returns the discoverable parameter tables.
// - Delivery state: array bytes FFH, status 00H except quad-enable bit S9.
// - Write-in-progress reads 1 during a self-timed cycle, 0 after it.
// - Software reset is 66H frame then 99H frame, accepted in any mode and asleep.
`default_nettype none

package fpm_pkg;

    // Opcodes
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_ID = 8'hAB;
    localparam logic [7:0] OP_QUAD_ON = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF = 8'hFF;
    localparam logic [7:0] OP_PARAM_READ = 8'h5A;
    localparam logic [7:0] OP_RST_ENABLE = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;

    // Frame lengths in serial clock beats
    localparam logic [5:0] SPI_OP_BEATS = 6'h08;
    localparam logic [5:0] QUAD_OP_BEATS = 6'h02;
    localparam logic [5:0] SPI_ADDR_BEATS = 6'h20;
    localparam logic [5:0] QUAD_ADDR_BEATS = 6'h08;
    localparam logic [5:0] SPI_PARAM_HDR = 6'h28;
    localparam logic [5:0] QUAD_PARAM_HDR = 6'h0A;
    localparam logic [5:0] NO_DATA_HDR = 6'h3F;
    localparam logic [2:0] SPI_LAST_SUB = 3'h7;
    localparam logic [2:0] QUAD_LAST_SUB = 3'h1;

    // Timing
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned SLEEP_ENTRY_NS = 3000;
    localparam int unsigned WAKE_NS = 8000;
    localparam int unsigned ID_WAKE_NS = 8000;
    localparam int unsigned SW_RESET_NS = 30000;
    localparam int unsigned POWERUP_US = 700;
    localparam logic [11:0] SLEEP_ENTRY_CYC = 12'((SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] WAKE_CYC = 12'((WAKE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] ID_WAKE_CYC = 12'((ID_WAKE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] SW_RESET_CYC = 12'((SW_RESET_NS * CLK_MHZ + 999) / 1000);
    localparam int unsigned POWERUP_CYC = POWERUP_US * CLK_MHZ;

    // Status word
    localparam logic [15:0] STATUS_RESET = 16'h0200;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_LATCH_BIT = 1;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Parameter table, signature first
    localparam int unsigned PARAM_TABLE_LEN = 8;
    localparam logic [7:0] PARAM_TABLE [PARAM_TABLE_LEN] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hFF
    };

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_ENTER = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b011,
        ST_RESET = 3'b100
    } fpm_state_e;

    typedef struct packed {
        logic quad;
        logic asleep;
        logic busy;
    } fpm_link_cfg_s;

    typedef struct packed {
        logic [5:0] beats;
        logic [7:0] op;
    } fpm_frame_s;

    function automatic logic [5:0] op_beats(input logic quad);
        return quad ? QUAD_OP_BEATS : SPI_OP_BEATS;
    endfunction

    function automatic logic [5:0] addr_beats(input logic quad);
        return quad ? QUAD_ADDR_BEATS : SPI_ADDR_BEATS;
    endfunction

    // Beats before the first output bit of a read-type opcode
    function automatic logic [5:0] hdr_beats(input logic quad, input logic [7:0] op);
        if (op == OP_WAKE_ID) begin
            return addr_beats(quad);
        end
        if (op == OP_PARAM_READ) begin
            return quad ? QUAD_PARAM_HDR : SPI_PARAM_HDR;
        end
        return NO_DATA_HDR;
    endfunction

endpackage

`default_nettype wire

// [tb/fpm_host_model.sv]
// Host serial controller model that drives chip select, serial clock and data lines.
// Assumes the device samples on rising and drives on falling serial clock edges.
`timescale 1ns/1ps
`default_nettype none

module fpm_host_model (
    // Link towards the device
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h0;
    end

    // Serial clock only runs inside a frame; the caller sets the frame length in beats
    task automatic xfer(input logic quad, input logic [63:0] tx, input int ntx, input int nrx,
                        output logic [15:0] rx, output logic [3:0] oe);
        int i;
        rx = 16'h0000;
        oe = 4'h0;
        cs_n = 1'b0;
        #24;
        for (i = 0; i < ntx; i++) begin
            io_in = quad ? tx[63:60] : {io_in[3:1], tx[63]};
            tx = quad ? (tx << 4) : (tx << 1);
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        for (i = 0; i < nrx; i++) begin
            #24;
            rx = quad ? {rx[11:0], io_out} : {rx[14:0], io_out[1]};
            oe = io_oe;
            sclk = 1'b1;
            #24 sclk = 1'b0;
        end
        #24 cs_n = 1'b1;
        // Released lines must not keep showing the last value
        io_in = ~io_in;
        // Chip select stays high long enough for the device to take the frame
        #200;
    endtask
endmodule // fpm_host_model

`default_nettype wire

// [tb/flash_power_mode_commands_tb.sv]
// Self-checking bench for the power state and interface mode command block.
// Assumes the host model in the same folder and a shortened power-up wait.
`timescale 1ns/1ps
`default_nettype none

module flash_power_mode_commands_tb;
    localparam logic [7:0] ID_VAL = 8'hA7;  // Arbitrary identifier value
    localparam int LIMIT = 30000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic write_in_progress_flag = 1'b0;
    logic write_enable_latch = 1'b0;
    wire logic sclk;
    wire logic cs_n;
    wire logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic core_reset;
    logic deep_sleep;
    logic standby;
    logic quad_mode;
    logic ready;
    logic [15:0] status_word;
    logic rst_seen = 1'b0;
    logic [15:0] rx;
    logic [3:0] oe;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    fpm_core #(.DEVICE_ID(ID_VAL), .POWERUP_CYC(20)) dut_u (
        .clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .write_in_progress_flag(write_in_progress_flag),
        .write_enable_latch(write_enable_latch),
        .core_reset(core_reset), .deep_sleep(deep_sleep), .standby(standby),
        .quad_mode(quad_mode), .ready(ready), .status_word(status_word)
    );

    fpm_host_model host_u (
        .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe)
    );

    task automatic complete_run();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One opcode frame, then enough chip-select high time for the frame to be taken
    task automatic op(input logic quad, input logic [7:0] code, input int beats);
        host_u.xfer(quad, {code, 56'h0}, beats, 0, rx, oe);
        wait_clk(10);
    endtask

    always @(posedge clk) begin
        if (core_reset === 1'b1) begin
            rst_seen <= 1'b1;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        int n;
        wait_clk(2);
        check("status at reset", status_word, 16'h0200);
        arst_n = 1'b1;
        for (n = 0; n < 100 && ready !== 1'b1; n++) begin
            wait_clk(1);
        end
        check("ready", 16'(ready), 16'h0001);
        wait_clk(5);
        check("standby", 16'(standby), 16'h0001);
        check("sleep after power-up", 16'(deep_sleep), 16'h0000);
        op(1'b0, 8'hB9, 7);
        op(1'b0, 8'hB9, 9);
        wait_clk(200);
        check("sleep on bad length", 16'(deep_sleep), 16'h0000);
        write_in_progress_flag = 1'b1;
        op(1'b0, 8'hB9, 8);
        wait_clk(200);
        check("sleep while busy", 16'(deep_sleep), 16'h0000);
        check("busy status", status_word, 16'h0201);
        check("standby while busy", 16'(standby), 16'h0000);
        host_u.xfer(1'b0, {8'hAB, 56'h0}, 32, 8, rx, oe);
        check("id enable while busy", 16'(oe), 16'h0000);
        wait_clk(1);
        write_in_progress_flag = 1'b0;
        wait_clk(5);
        check("idle status", status_word, 16'h0200);
        op(1'b0, 8'hB9, 8);
        wait_clk(100);
        check("sleep before entry delay", 16'(deep_sleep), 16'h0000);
        wait_clk(60);
        check("sleep entered", 16'(deep_sleep), 16'h0001);
        op(1'b0, 8'h38, 8);
        check("mode change asleep", 16'(quad_mode), 16'h0000);
        host_u.xfer(1'b0, {8'h5A, 56'h0}, 40, 8, rx, oe);
        check("table enable asleep", 16'(oe), 16'h0000);
        wait_clk(1);
        write_in_progress_flag = 1'b1;
        op(1'b0, 8'hAB, 8);
        check("wake while busy", 16'(deep_sleep), 16'h0001);
        write_in_progress_flag = 1'b0;
        op(1'b0, 8'hAB, 8);
        check("woken", 16'(deep_sleep), 16'h0000);
        op(1'b0, 8'h38, 8);
        check("command in wake delay", 16'(quad_mode), 16'h0000);
        wait_clk(420);
        host_u.xfer(1'b0, {8'hAB, 56'h0}, 32, 16, rx, oe);
        check("identifier twice", rx, {ID_VAL, ID_VAL});
        check("identifier enable", 16'(oe), 16'h0002);
        op(1'b0, 8'hB9, 8);
        wait_clk(200);
        host_u.xfer(1'b0, {8'hAB, 56'h0}, 32, 8, rx, oe);
        check("identifier from sleep", rx, 16'(ID_VAL));
        wait_clk(10);
        check("woken by identify", 16'(deep_sleep), 16'h0000);
        op(1'b0, 8'h38, 8);
        check("command in identify delay", 16'(quad_mode), 16'h0000);
        wait_clk(420);
        write_enable_latch = 1'b1;
        op(1'b0, 8'h38, 8);
        check("quad on", 16'(quad_mode), 16'h0001);
        check("latch kept", status_word, 16'h0202);
        host_u.xfer(1'b1, {8'h5A, 32'h0, 24'h0}, 10, 4, rx, oe);
        check("table bytes", rx, 16'h5346);
        check("table enable", 16'(oe), 16'h000F);
        wait_clk(10);
        op(1'b1, 8'hFF, 2);
        check("quad off", 16'(quad_mode), 16'h0000);
        check("latch kept back", status_word, 16'h0202);
        op(1'b0, 8'h38, 8);
        op(1'b1, 8'h66, 2);
        op(1'b1, 8'h99, 2);
        check("reset pulse", 16'(rst_seen), 16'h0001);
        check("reset clears quad", 16'(quad_mode), 16'h0000);
        wait_clk(1600);
        op(1'b0, 8'hB9, 8);
        wait_clk(200);
        op(1'b0, 8'h66, 8);
        op(1'b0, 8'h99, 8);
        check("reset from sleep", 16'(deep_sleep), 16'h0000);
        complete_run();
    end
endmodule // flash_power_mode_commands_tb

`default_nettype wire
